// [irq_source_model.sv]
// Interrupt sources that hold a wake request until the core runs again
`timescale 1ns/100ps
module irq_source_model
	import standby_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic fire_in,
	input wire wake_req_t bits_in,
	input wire logic [3:0] delay_in,
	input wire logic cpu_run_in,
	output wake_req_t wake_req_out
);
	logic [3:0] count_q;
	wake_req_t pend_q;
	// Flags stay up until serviced, as a real source would keep them
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_q <= 4'h0;
			pend_q <= '0;
			wake_req_out <= '0;
		end else if (fire_in) begin
			count_q <= delay_in;
			pend_q <= bits_in;
		end else if (count_q != 4'h0) begin
			count_q <= count_q - 4'h1;
		end else begin
			wake_req_out <= cpu_run_in ? '0 : (wake_req_out | pend_q);
			pend_q <= cpu_run_in ? '0 : pend_q;
		end
	end
endmodule

// [standby_pkg.sv]
// Register map, field layout, timing and types for the standby and wakeup controller
package standby_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [3:0] OFS_MODE = 4'h0;
	localparam logic [3:0] OFS_OSC = 4'h4;
	localparam logic [3:0] OFS_CFG = 4'h8;
	localparam logic [3:0] OFS_CAUSE = 4'hc;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int CMD_HALT_BIT = 0;
	localparam int CMD_HOLD_BIT = 1;
	localparam int CMD_XHOLD_BIT = 2;
	localparam int CFG_A_LEVEL_BIT = 0;
	localparam int CFG_B_LEVEL_BIT = 1;
	localparam int CFG_BT_LOWRC_BIT = 2;
	localparam int CFG_W = 3;
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam int OSC_W = 5;
	localparam logic [4:0] OSC_RESET = 5'h04;
	localparam int CAUSE_PIN = 0;
	localparam int CAUSE_WDT = 1;
	localparam int CAUSE_LVR = 2;
	localparam int CAUSE_POR = 3;
	localparam int CAUSE_IRQ = 4;
	localparam int CAUSE_EXT = 5;
	localparam int CAUSE_PORT0 = 6;
	localparam int CAUSE_USB = 7;
	localparam int CAUSE_BT = 8;
	localparam int CAUSE_IR = 9;
	localparam int CAUSE_W = 10;
	localparam logic [9:0] CAUSE_RESET = 10'h000;

	////////////////////////////////////////////////////////////////////////////////
	// Supply supervisor options and timing
	localparam int POR_LEVELS = 8;
	localparam int LVR_LEVELS = 7;
	localparam int MED_RC_KHZ = 1000;
	localparam int LOW_RC_KHZ = 30;
	localparam int SYS_CLK_KHZ = 20000;
	localparam int RESTART_NS = 1000;
	localparam int RESTART_CYCLES = (RESTART_NS * SYS_CLK_KHZ + 999999) / 1000000;

	////////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_HALT = 5'h02,
		ST_HOLD = 5'h04,
		ST_XHOLD = 5'h08,
		ST_WAKE = 5'h10
	} mode_state_t;

	typedef struct packed {
		logic pll;
		logic ceramic;
		logic med_rc;
		logic low_rc;
		logic crystal;
	} osc_en_t;

	typedef struct packed {
		logic ext_irq_line_a;
		logic ext_irq_line_b;
		logic ext_irq_line_c;
		logic ext_irq_line_e;
		logic ext_irq_line_f;
		logic port0;
		logic usb_bus_active;
		logic base_timer;
		logic ir_rx;
		logic any_other;
	} wake_req_t;

endpackage

// [standby_wakeup_control.sv]
// Standby mode sequencer, oscillator gating, supply resets and register slave
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps

// Summary of operation
// - Medium-speed RC, about 1 MHz, clock candidate
// - Low-speed RC, about 30 kHz, clock candidate
// - Power-on reset, release level from eight options
// - Low-voltage reset optional, seven threshold levels
// - HALT stops execution, peripherals keep running
// - HALT leaves every oscillator as it was
// - HALT ends on reset or any interrupt
// - HOLD stops execution and all peripherals
// - HOLD stops PLL, ceramic, RC, crystal oscillators
// - Watchdog owns low-speed RC during standby, except crystal-hold with the base timer low-RC bit set keeps its entry state
// - HOLD modes end on any reset source
// - HOLD modes end on lines a,b,c,e,f
// - Lines a,b wake HOLD modes only in level mode
// - Port 0 interrupt ends both HOLD modes
// - USB bus-active interrupt ends both HOLD modes
// - Crystal-hold keeps base timer and IR running
// - Crystal-hold stops PLL, ceramic and RC oscillators
// - Crystal-hold keeps crystal entry state
// - Low RC kept if it clocks base timer
// - Base timer interrupt ends crystal-hold
// - IR receiver interrupt ends crystal-hold
module standby_wakeup_control
	import standby_pkg::*;
#(
	parameter logic [2:0] POR_LEVEL_SEL = 3'h0,
	parameter logic LVR_ENABLE = 1'b1,
	parameter logic [2:0] LVR_LEVEL_SEL = 3'h0,
	parameter int RESTART_CYC = RESTART_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [DATA_W-1:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [DATA_W-1:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic res_pin_n_in,
	input wire logic wdt_reset_in,
	input wire logic wdt_low_rc_en_in,
	input wire logic [POR_LEVELS-1:0] por_above_in,
	input wire logic [LVR_LEVELS-1:0] lvr_above_in,
	input wire wake_req_t wake_req_in,
	output logic core_reset_out,
	output logic cpu_run_out,
	output logic periph_run_out,
	output logic bt_ir_run_out,
	output osc_en_t osc_en_out,
	output mode_state_t mode_out
);

	localparam int SYNC_W = 1 + POR_LEVELS + LVR_LEVELS;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [3:0] ofs);
		hit = (addr == ofs);
	endfunction
	function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] be);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		lane_mask = m;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic res_pin_low;
	logic [POR_LEVELS-1:0] por_ok;
	logic [LVR_LEVELS-1:0] lvr_ok;
	logic por_q;
	logic lvr_trip;
	logic reset_src;
	logic wait_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] wmask;
	logic mode_wr;
	logic osc_wr;
	logic cfg_wr;
	logic cause_wr;
	osc_en_t osc_q;
	logic [CFG_W-1:0] cfg_q;
	logic [CAUSE_W-1:0] cause_q;
	logic [CAUSE_W-1:0] cause_set;
	mode_state_t state_q;
	mode_state_t state_d;
	logic [15:0] restart_cnt_q;
	logic xtal_keep_q;
	logic low_rc_keep_q;
	logic line_ab_wake;
	logic hold_wake;
	logic xhold_wake;
	logic halt_wake;
	osc_en_t osc_d;
	logic core_reset_q;
	logic cpu_run_q;
	logic periph_run_q;
	logic bt_ir_run_q;
	osc_en_t osc_out_q;
	mode_state_t mode_out_q;

	////////////////////////////////////////////////////////////////////////////////
	// Pin and comparator synchronisers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {res_pin_n_in, por_above_in, lvr_above_in};
			sync2_q <= sync1_q;
		end
	end
	assign res_pin_low = ~sync2_q[SYNC_W-1];
	assign por_ok = sync2_q[LVR_LEVELS +: POR_LEVELS];
	assign lvr_ok = sync2_q[LVR_LEVELS-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// Supply resets
	// Asserted from power-up until the chosen level is crossed
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			por_q <= 1'b1;
		end else begin
			por_q <= ~por_ok[POR_LEVEL_SEL];
		end
	end
	// Levels beyond the seventh are not valid and never trip
	assign lvr_trip = LVR_ENABLE && (LVR_LEVEL_SEL < 3'(LVR_LEVELS))
		&& !lvr_ok[LVR_LEVEL_SEL];
	assign reset_src = res_pin_low | wdt_reset_in | lvr_trip | por_q;

	////////////////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, answer on the second edge
	assign wmask = lane_mask(avs_byteenable_in);
	assign mode_wr = avs_write_in & ~wait_q & hit(avs_address_in, OFS_MODE);
	assign osc_wr = avs_write_in & ~wait_q & hit(avs_address_in, OFS_OSC);
	assign cfg_wr = avs_write_in & ~wait_q & hit(avs_address_in, OFS_CFG);
	assign cause_wr = avs_write_in & ~wait_q & hit(avs_address_in, OFS_CAUSE);
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
		end
	end
	always_comb begin
		rdata_d = '0;
		if (hit(avs_address_in, OFS_MODE)) begin
			rdata_d[4:0] = state_q;
		end else if (hit(avs_address_in, OFS_OSC)) begin
			rdata_d[OSC_W-1:0] = osc_q;
		end else if (hit(avs_address_in, OFS_CFG)) begin
			rdata_d[CFG_W-1:0] = cfg_q;
		end else if (hit(avs_address_in, OFS_CAUSE)) begin
			rdata_d[CAUSE_W-1:0] = cause_q;
		end
	end
	// Captured during the wait cycle so data stands when waitrequest drops
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= '0;
		end else if (avs_read_in && wait_q) begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			osc_q <= OSC_RESET;
		end else if (osc_wr) begin
			osc_q <= (osc_q & ~wmask[OSC_W-1:0]) | (avs_writedata_in[OSC_W-1:0] & wmask[OSC_W-1:0]);
		end
	end
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_q <= CFG_RESET;
		end else if (cfg_wr) begin
			cfg_q <= (cfg_q & ~wmask[CFG_W-1:0]) | (avs_writedata_in[CFG_W-1:0] & wmask[CFG_W-1:0]);
		end
	end
	// Write one to clear; a cause arriving in the same cycle stays set
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cause_q <= CAUSE_RESET;
		end else if (cause_wr) begin
			cause_q <= (cause_q & ~(avs_writedata_in[CAUSE_W-1:0] & wmask[CAUSE_W-1:0])) | cause_set;
		end else begin
			cause_q <= cause_q | cause_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wake qualification
	// Edge-mode requests on lines a and b cannot end either HOLD mode
	assign line_ab_wake = (wake_req_in.ext_irq_line_a & cfg_q[CFG_A_LEVEL_BIT])
		| (wake_req_in.ext_irq_line_b & cfg_q[CFG_B_LEVEL_BIT]);
	assign hold_wake = line_ab_wake | wake_req_in.ext_irq_line_c | wake_req_in.ext_irq_line_e
		| wake_req_in.ext_irq_line_f
		| wake_req_in.port0
		| wake_req_in.usb_bus_active;
	assign xhold_wake = hold_wake | wake_req_in.base_timer
		| wake_req_in.ir_rx;
	assign halt_wake = |wake_req_in;

	always_comb begin
		cause_set = '0;
		cause_set[CAUSE_PIN] = res_pin_low;
		cause_set[CAUSE_WDT] = wdt_reset_in;
		cause_set[CAUSE_LVR] = lvr_trip;
		cause_set[CAUSE_POR] = por_q;
		if (state_q == ST_HALT) begin
			cause_set[CAUSE_IRQ] = halt_wake;
		end
		if (state_q == ST_HOLD || state_q == ST_XHOLD) begin
			cause_set[CAUSE_EXT] = line_ab_wake | wake_req_in.ext_irq_line_c
				| wake_req_in.ext_irq_line_e | wake_req_in.ext_irq_line_f;
			cause_set[CAUSE_PORT0] = wake_req_in.port0;
			cause_set[CAUSE_USB] = wake_req_in.usb_bus_active;
		end
		if (state_q == ST_XHOLD) begin
			cause_set[CAUSE_BT] = wake_req_in.base_timer;
			cause_set[CAUSE_IR] = wake_req_in.ir_rx;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				// Crystal-hold wins over HOLD, and HOLD over HALT, if several command bits are written
				if (mode_wr && wmask[0] && avs_writedata_in[CMD_XHOLD_BIT]) begin
					state_d = ST_XHOLD;
				end else if (mode_wr && wmask[0] && avs_writedata_in[CMD_HOLD_BIT]) begin
					state_d = ST_HOLD;
				end else if (mode_wr && wmask[0] && avs_writedata_in[CMD_HALT_BIT]) begin
					state_d = ST_HALT;
				end
			end
			ST_HALT: begin
				if (halt_wake) begin
					state_d = ST_RUN;
				end
			end
			ST_HOLD: begin
				if (hold_wake) begin
					state_d = ST_WAKE;
				end
			end
			ST_XHOLD: begin
				if (xhold_wake) begin
					state_d = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (restart_cnt_q == 16'h0000) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end
	// Any reset source returns straight to run through the core reset
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_RUN;
		end else if (reset_src) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end
	// Gives restarted oscillators time to settle before execution resumes
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			restart_cnt_q <= 16'h0000;
		end else if (state_q != ST_WAKE) begin
			restart_cnt_q <= 16'(RESTART_CYC - 1);
		end else if (restart_cnt_q != 16'h0000) begin
			restart_cnt_q <= restart_cnt_q - 16'h0001;
		end
	end
	// Entry snapshot of the oscillators crystal-hold must preserve
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			xtal_keep_q <= 1'b0;
			low_rc_keep_q <= 1'b0;
		end else if (state_q == ST_RUN && state_d == ST_XHOLD && !reset_src) begin
			xtal_keep_q <= osc_out_q.crystal;
			low_rc_keep_q <= osc_out_q.low_rc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator gating
	always_comb begin
		case (state_q)
			ST_RUN, ST_HALT, ST_WAKE: begin
				osc_d = osc_q;
				osc_d.low_rc = osc_q.low_rc | wdt_low_rc_en_in;
			end
			ST_HOLD: begin
				osc_d = '0;
				osc_d.low_rc = wdt_low_rc_en_in;
			end
			ST_XHOLD: begin
				osc_d = '0;
				osc_d.crystal = xtal_keep_q;
				if (cfg_q[CFG_BT_LOWRC_BIT]) begin
					osc_d.low_rc = low_rc_keep_q;
				end else begin
					osc_d.low_rc = wdt_low_rc_en_in;
				end
			end
			default: begin
				osc_d = osc_q;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			core_reset_q <= 1'b1;
			cpu_run_q <= 1'b0;
			periph_run_q <= 1'b0;
			bt_ir_run_q <= 1'b0;
			osc_out_q <= OSC_RESET;
			mode_out_q <= ST_RUN;
		end else begin
			core_reset_q <= reset_src;
			cpu_run_q <= (state_q == ST_RUN) && !reset_src;
			periph_run_q <= (state_q == ST_RUN || state_q == ST_HALT) && !reset_src;
			bt_ir_run_q <= (state_q == ST_RUN || state_q == ST_HALT || state_q == ST_XHOLD)
				&& !reset_src;
			osc_out_q <= osc_d;
			mode_out_q <= state_q;
		end
	end

	assign avs_readdata_out = rdata_q;
	assign avs_waitrequest_out = wait_q;
	assign core_reset_out = core_reset_q;
	assign cpu_run_out = cpu_run_q;
	assign periph_run_out = periph_run_q;
	assign bt_ir_run_out = bt_ir_run_q;
	assign osc_en_out = osc_out_q;
	assign mode_out = mode_out_q;

endmodule

// [standby_wakeup_control_chk.sv]
// Port checker for the standby and wakeup controller
`timescale 1ns/100ps
module standby_wakeup_control_chk
	import standby_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic res_pin_n_in,
	input wire logic wdt_reset_in,
	input wire logic wdt_low_rc_en_in,
	input wire wake_req_t wake_req_in,
	input wire logic core_reset_out,
	input wire logic cpu_run_out,
	input wire logic periph_run_out,
	input wire logic bt_ir_run_out,
	input wire osc_en_t osc_en_out,
	input wire mode_state_t mode_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic quiet;
	// Reset sources override every mode, so mode checks skip them
	assign quiet = res_pin_n_in && !wdt_reset_in && !core_reset_out;
	////////////////////////////////////////
	sequence hold_clean;
		mode_out == ST_HOLD && quiet && (wake_req_in & 10'h3f8) == 10'h000
			&& $past(res_pin_n_in, 2) && $past(res_pin_n_in, 3);
	endsequence
	sequence wake_done;
		mode_out == ST_WAKE && quiet ##1 mode_out == ST_RUN && quiet;
	endsequence
	////////////////////////////////////////
	a_halt_runs: assert property (mode_out == ST_HALT && quiet |->
		!cpu_run_out && periph_run_out && bt_ir_run_out) else $error("halt run levels wrong");
	a_halt_wakes: assert property (mode_out == ST_HALT && quiet && wake_req_in != 10'h000
		|-> ##[1:2] mode_out == ST_RUN) else $error("halt not released");
	a_hold_off: assert property (mode_out == ST_HOLD && quiet |->
		!cpu_run_out && !periph_run_out && !bt_ir_run_out
		&& {osc_en_out} == {3'h0, $past(wdt_low_rc_en_in), 1'b0}) else $error("hold not stopped");
	a_hold_ignores: assert property (hold_clean [*2] |=> mode_out == ST_HOLD)
		else $error("hold left without cause");
	a_line_wakes: assert property ((mode_out == ST_HOLD || mode_out == ST_XHOLD) && quiet
		&& (wake_req_in & 10'h0f8) != 10'h000 |-> ##[1:2] mode_out == ST_WAKE)
		else $error("line did not wake");
	a_xhold_keeps: assert property (mode_out == ST_XHOLD && quiet |->
		bt_ir_run_out && !periph_run_out && !cpu_run_out
		&& !(osc_en_out.pll || osc_en_out.ceramic || osc_en_out.med_rc)) else $error("xhold wrong");
	a_xhold_crystal: assert property (mode_out == ST_XHOLD && $past(mode_out) == ST_XHOLD
		|-> $stable(osc_en_out.crystal)) else $error("crystal changed");
	a_xhold_wakes: assert property (mode_out == ST_XHOLD && quiet
		&& (wake_req_in & 10'h006) != 10'h000 |-> ##[1:2] mode_out == ST_WAKE)
		else $error("xhold not released");
	a_wdt_resets: assert property (wdt_reset_in |-> ##[1:2] core_reset_out && !cpu_run_out)
		else $error("watchdog reset lost");
	a_wake_restarts: assert property (wake_done |-> cpu_run_out && periph_run_out)
		else $error("no restart after wake");
endmodule

bind standby_wakeup_control standby_wakeup_control_chk i_standby_wakeup_control_chk (
	.sys_clk_in, .rst_n_in, .res_pin_n_in, .wdt_reset_in, .wdt_low_rc_en_in, .wake_req_in,
	.core_reset_out, .cpu_run_out, .periph_run_out, .bt_ir_run_out, .osc_en_out, .mode_out);

// [test_standby_wakeup_control.sv]
// Self-checking bench for the standby and wakeup controller
`timescale 1ns/100ps
module test_standby_wakeup_control;
	import standby_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic pin_n = 1'b1;
	logic wdt_rst = 1'b0;
	logic wdt_rc = 1'b0;
	logic fire = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [3:0] be = 4'hf;
	logic [3:0] dly = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [7:0] por_ok = 8'h00;
	logic [6:0] lvr_ok = 7'h00;
	wake_req_t bits = '0;
	wake_req_t wake;
	logic [31:0] rdat;
	logic [31:0] q;
	logic wait_req, core_rst, cpu_run, per_run, btir_run;
	osc_en_t osc;
	mode_state_t mode;
	mode_state_t m;
	logic [13:0] st;
	logic [4:0] os;
	logic [2:0] cfg;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int cb;
	assign st = {mode, osc, core_rst, cpu_run, per_run, btir_run};
	always #25 clk = ~clk;
	standby_wakeup_control #(.RESTART_CYC(2)) i_standby_wakeup_control (
		.sys_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wait_req), .res_pin_n_in(pin_n),
		.wdt_reset_in(wdt_rst), .wdt_low_rc_en_in(wdt_rc), .por_above_in(por_ok),
		.lvr_above_in(lvr_ok), .wake_req_in(wake), .core_reset_out(core_rst),
		.cpu_run_out(cpu_run), .periph_run_out(per_run), .bt_ir_run_out(btir_run),
		.osc_en_out(osc), .mode_out(mode));
	irq_source_model i_irq_source_model (.sys_clk_in(clk), .rst_n_in(rst_n), .fire_in(fire),
		.bits_in(bits), .delay_in(dly), .cpu_run_in(cpu_run), .wake_req_out(wake));
	////////////////////////////////////////
	function automatic logic [13:0] expect_st(mode_state_t md, logic [4:0] o, logic w, logic k);
		logic [4:0] e;
		logic [3:0] r;
		e = o | {3'h0, w, 1'b0};
		r = 4'b0111;
		if (md == ST_HALT) r = 4'b0011;
		if (md == ST_HOLD) e = {3'h0, w, 1'b0};
		if (md == ST_HOLD) r = 4'b0000;
		if (md == ST_XHOLD) e = {3'h0, k ? o[1] | w : w, o[0]};
		if (md == ST_XHOLD) r = 4'b0001;
		return {md, e, r};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] e);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		be <= e;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 20);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20) miscompares++;
	endtask
	task automatic wait_mode(input mode_state_t md);
		int n;
		n = 0;
		while (mode !== md && n < 60) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic wait_free();
		int n;
		n = 0;
		while (core_rst !== 1'b0 && n < 40) begin
			@(posedge clk);
			n++;
		end
		check(32'(core_rst), 32'h0);
	endtask
	task automatic fire_req(input wake_req_t b, input logic [3:0] d);
		@(posedge clk);
		fire <= 1'b1;
		bits <= b;
		dly <= d;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	////////////////////////////////////////
	initial begin
		q = $urandom(48191);
		repeat (2) @(posedge clk);
		check(32'(st), 32'({ST_RUN, 5'h04, 4'b1000}));
		rst_n <= 1'b1;
		lvr_ok <= 7'h7f;
		repeat (6) @(posedge clk);
		check(32'(core_rst), 32'h1);
		por_ok <= 8'h01;
		wait_free();
		check(32'(st), 32'(expect_st(ST_RUN, 5'h04, 1'b0, 1'b0)));
		done("power up");
		bus(1'b0, OFS_OSC, 32'h0, 4'hf);
		check(q, 32'h4);
		bus(1'b0, OFS_CFG, 32'h0, 4'hf);
		check(q, 32'h0);
		bus(1'b0, OFS_CAUSE, 32'h0, 4'hf);
		check(32'(q[CAUSE_POR]), 32'h1);
		bus(1'b1, 4'h6, 32'hffff_ffff, 4'hf);
		bus(1'b1, OFS_OSC, 32'h1f, 4'h0);
		bus(1'b0, 4'h6, 32'h0, 4'hf);
		check(q, 32'h0);
		bus(1'b0, OFS_OSC, 32'h0, 4'hf);
		check(q, 32'h4);
		done("registers");
		for (int i = 0; i < 4; i++) begin
			os = 5'($urandom);
			wdt_rc <= 1'($urandom);
			bus(1'b1, OFS_OSC, 32'(os), 4'hf);
			bus(1'b1, OFS_MODE, 32'h1, 4'h1);
			wait_mode(ST_HALT);
			check(32'(st), 32'(expect_st(ST_HALT, os, wdt_rc, 1'b0)));
			fire_req(10'(11'h1 << ($urandom % 10)), 4'($urandom));
			wait_mode(ST_RUN);
			check(32'(st), 32'(expect_st(ST_RUN, os, wdt_rc, 1'b0)));
		end
		done("halt");
		bus(1'b1, OFS_CAUSE, 32'h3ff, 4'hf);
		// Entry 0 runs line a in edge mode, 8 and 9 use crystal-hold
		for (int k = 0; k < 10; k++) begin
			cfg = (k == 0) ? 3'h0 : {k == 9, 2'b11};
			m = (k < 8) ? ST_HOLD : ST_XHOLD;
			os = 5'($urandom);
			wdt_rc <= 1'($urandom);
			bus(1'b1, OFS_OSC, 32'(os), 4'hf);
			bus(1'b1, OFS_CFG, 32'(cfg), 4'hf);
			bus(1'b1, OFS_MODE, (k < 8) ? 32'h2 : 32'h4, 4'h1);
			wait_mode(m);
			check(32'(st), 32'(expect_st(m, os, wdt_rc, cfg[2])));
			fire_req((k == 0) ? 10'h207 : (k < 8) ? 10'h007 : 10'h001, 4'h0);
			repeat (8) @(posedge clk);
			check(32'(st), 32'(expect_st(m, os, wdt_rc, cfg[2])));
			fire_req((k == 0) ? 10'h080 : 10'(11'h400 >> k), 4'($urandom));
			wait_mode(ST_RUN);
			check(32'(st), 32'(expect_st(ST_RUN, os, wdt_rc, 1'b0)));
			cb = (k < 6) ? CAUSE_EXT : (k == 6) ? CAUSE_PORT0 : (k == 7) ? CAUSE_USB
				: (k == 8) ? CAUSE_BT : CAUSE_IR;
			bus(1'b0, OFS_CAUSE, 32'h0, 4'hf);
			check(q, 32'h1 << cb);
			bus(1'b1, OFS_CAUSE, 32'h3ff, 4'hf);
		end
		done("hold");
		for (int s = 0; s < 3; s++) begin
			bus(1'b1, OFS_MODE, 32'(3'h1 << s), 4'h1);
			wait_mode(mode_state_t'(5'h2 << s));
			case (s)
				0: lvr_ok <= 7'h00;
				1: wdt_rst <= 1'b1;
				default: pin_n <= 1'b0;
			endcase
			repeat (8) @(posedge clk);
			check(32'({mode, core_rst, cpu_run}), 32'({ST_RUN, 2'b10}));
			lvr_ok <= 7'h7f;
			wdt_rst <= 1'b0;
			pin_n <= 1'b1;
			wait_free();
			cb = (s == 0) ? CAUSE_LVR : (s == 1) ? CAUSE_WDT : CAUSE_PIN;
			bus(1'b0, OFS_CAUSE, 32'h0, 4'hf);
			check(q, 32'h1 << cb);
			bus(1'b1, OFS_CAUSE, 32'h3ff, 4'hf);
		end
		done("reset sources");
		close_out();
	end
endmodule
